/* rtl/msg_store_pkg.sv */
// Constants and types for the keyed message store controller
package msg_store_pkg;
  localparam int CHAR_W = 7;
  localparam int ADDR_W = 10;
  localparam int BIT_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_EMPTY = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 10'h3FF;
  localparam logic [ADDR_W-1:0] WARN_FROM = 10'h3EF;
  localparam logic [ADDR_W-1:0] LOCK_FROM = 10'h3F7;
  localparam logic [BIT_W-1:0] BT_FIRST = 3'h0;
  localparam logic [BIT_W-1:0] BT_CBIT = 3'h6;
  localparam logic [BIT_W-1:0] BT_LAST = 3'h7;
  // End marker codes, both odd weight; values arbitrary
  localparam logic [CHAR_W-1:0] MARK_PLAIN = 7'h07;
  localparam logic [CHAR_W-1:0] MARK_CHECKED = 7'h0B;
  localparam int WR_W = ADDR_W + BIT_W + 1;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_HZ = 20_000_000;
  localparam int IDLE_SEC = 15;
  localparam int IDLE_CYC = IDLE_SEC * CLK_HZ;
  localparam int TCNT_W = 29;
  typedef enum logic [1:0] {
    PH_STAGE = 2'b00,
    PH_WRITE = 2'b01
  } phase_type;
endpackage : msg_store_pkg

/* rtl/msg_store_ctrl.sv */
// Keyed message store controller with its write FIFO
module bit_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_type;
  fifo_type s_q, s_d;
  logic push, pop;
  assign o_in_ready = (s_q.cnt != DEPTH[PW:0]);
  assign o_out_valid = (s_q.cnt != '0);
  assign o_out_data = s_q.mem[s_q.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  // Pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = i_in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : bit_fifo

module msg_store_ctrl
  import msg_store_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = IDLE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Operator keys and modes
  input wire logic i_enter_key,
  input wire logic i_printback_done,
  input wire logic i_backspace_key,
  input wire logic i_reset_key,
  input wire logic i_send_key,
  input wire logic i_line_return_key,
  input wire logic i_line_type_key,
  input wire logic i_communicate,
  input wire logic i_record_check,
  input wire logic i_answerback_tx,
  input wire logic i_single_cycle_halt,
  // Printer side
  input wire logic [CHAR_W-1:0] i_key_bits,
  input wire logic i_strobe,
  input wire logic i_io_cycle,
  input wire logic i_upper_case,
  output logic o_downshift,
  output logic o_motor_on,
  output logic o_kbd_unlock,
  output logic o_bell,
  // Lamps and status
  output logic o_enter_lamp,
  output logic o_standby_lamp,
  output logic o_status,
  output logic o_parity_error,
  output logic o_hold_loaded,
  output logic o_text_nonselected,
  output logic o_send_request,
  output logic o_printback_start,
  // Buffer store bit writes
  output logic o_wr_valid,
  output logic [WR_W-1:0] o_wr_data,
  input wire logic i_wr_ready
);
  typedef struct packed {
    logic enter;
    logic ild;
    logic entry_req;
    logic [CHAR_W-1:0] hold;
    logic loaded;
    logic clr;
    logic clr_gate;
    logic strobe_d;
    logic run;
    phase_type ph;
    logic [BIT_W-1:0] cnt;
    logic stage;
    logic par;
    logic perr;
    logic [ADDR_W-1:0] addr;
    logic arm;
    logic [TCNT_W-1:0] tcnt;
    logic tmo;
    logic bid;
    logic stop;
    logic rst_pend;
    logic blink;
    logic bell;
    logic tns;
    logic send_req;
    logic pb_start;
    logic downshift;
    logic motor;
    logic unlock;
    logic enter_lamp;
    logic status;
  } ctl_type;
  ctl_type s_q, s_d;
  logic fifo_rdy, push, start, done, quiet, warn, lock;
  logic [WR_W-1:0] push_data;

  assign warn = (s_q.addr >= WARN_FROM) && (s_q.addr < LOCK_FROM);
  assign lock = (s_q.addr >= LOCK_FROM);
  // Storage begins only once the printer strobe has gone away
  assign start = s_q.loaded && !i_strobe && !s_q.run;
  assign push = s_q.run && (s_q.ph == PH_WRITE);
  assign push_data = {s_q.addr, s_q.cnt, s_q.stage};
  assign done = s_q.run && (s_q.cnt == BT_LAST);
  assign quiet = s_q.arm && s_q.enter && i_communicate && !s_q.loaded
    && !i_enter_key && !i_line_return_key && !i_line_type_key;

  // Next state of the whole controller
  always_comb begin
    s_d = s_q;
    s_d.strobe_d = i_strobe;
    s_d.bell = 1'b0;
    s_d.tns = 1'b0;
    s_d.pb_start = 1'b0;
    // Entry request and downshift
    if (i_enter_key || (i_printback_done && !i_communicate)) begin
      s_d.entry_req = 1'b1;
    end
    // Print-back end restarts entry from an empty address as well
    if ((i_enter_key || (i_printback_done && !i_communicate)) && !s_q.run) begin
      s_d.addr = ADDR_EMPTY;
      if (i_upper_case) begin
        s_d.ild = 1'b1;
      end
    end
    if (!i_upper_case) begin
      s_d.ild = 1'b0;
    end
    if (s_q.entry_req && !i_upper_case && s_q.addr == ADDR_EMPTY) begin
      s_d.enter = 1'b1;
      s_d.entry_req = 1'b0;
    end
    // Load holding register on the strobe edge
    if (s_q.enter && i_strobe && !s_q.strobe_d && !s_q.loaded) begin
      s_d.hold = i_key_bits;
      s_d.loaded = 1'b1;
    end
    // Clear pulse, then gate held until the cycle ends
    if (s_q.loaded && i_io_cycle && !s_q.clr_gate && !s_q.stop) begin
      s_d.clr = 1'b1;
    end
    if (s_q.clr) begin
      s_d.clr = 1'b0;
      s_d.clr_gate = 1'b1;
      s_d.hold = s_q.hold & i_key_bits;
    end
    if (!i_io_cycle) begin
      s_d.clr_gate = 1'b0;
    end
    // Backspace never touches memory timing
    if (i_backspace_key && s_q.enter && !s_q.run && !s_q.loaded
        && s_q.addr != ADDR_EMPTY) begin
      s_d.addr = s_q.addr - 1'b1;
    end
    // Store cycle
    if (start) begin
      s_d.run = 1'b1;
      s_d.cnt = BT_FIRST;
      s_d.addr = s_q.addr + 1'b1;
      s_d.ph = PH_STAGE;
    end else if (done) begin
      s_d.run = 1'b0;
      s_d.hold = '0;
      s_d.loaded = 1'b0;
      s_d.par = 1'b0;
      if (s_q.stop) begin
        s_d.stop = 1'b0;
        s_d.bid = 1'b0;
        s_d.enter = 1'b0;
        s_d.send_req = i_communicate;
        s_d.pb_start = !i_communicate;
      end else if (warn) begin
        s_d.bell = 1'b1;
        s_d.blink = !s_q.blink;
      end
    end else if (s_q.run && s_q.ph == PH_STAGE) begin
      s_d.stage = s_q.hold[s_q.cnt];
      s_d.par = s_q.par ^ s_q.hold[s_q.cnt];
      s_d.ph = PH_WRITE;
    end else if (push && fifo_rdy) begin
      s_d.stage = 1'b0;
      s_d.cnt = s_q.cnt + 1'b1;
      s_d.ph = PH_STAGE;
      if (s_q.cnt == BT_CBIT && !s_q.par) begin
        s_d.perr = 1'b1;
        s_d.bell = 1'b1;
      end
    end
    // Send key: empty buffer ends entry at once
    if (i_send_key && s_q.enter && !s_q.bid) begin
      if (s_q.addr == ADDR_EMPTY && !s_q.loaded && !s_q.run) begin
        s_d.enter = 1'b0;
      end else begin
        s_d.bid = 1'b1;
      end
    end
    // Generated end marker, no printer cycle
    if (s_q.bid && !s_q.stop && !i_upper_case && !s_q.loaded && !s_q.run
        && !i_strobe) begin
      s_d.hold = i_record_check ? MARK_CHECKED : MARK_PLAIN;
      s_d.loaded = 1'b1;
      s_d.stop = 1'b1;
    end
    // Reset key waits for a store in progress
    if (i_reset_key) begin
      s_d.rst_pend = 1'b1;
      s_d.tns = i_communicate;
    end
    if (s_q.rst_pend && !s_q.run && !s_q.loaded) begin
      s_d.rst_pend = 1'b0;
      s_d.addr = ADDR_EMPTY;
      s_d.enter = 1'b0;
      s_d.perr = 1'b0;
      s_d.bid = 1'b0;
    end
    // Idle time-out; arming survives later sessions
    if (i_answerback_tx) begin
      s_d.arm = 1'b1;
    end
    if (quiet) begin
      if (s_q.tcnt != IDLE_CYCLES[TCNT_W-1:0] - 1'b1) begin
        s_d.tcnt = s_q.tcnt + 1'b1;
      end else if (!i_single_cycle_halt) begin
        s_d.tmo = 1'b1;
      end
    end else begin
      s_d.tcnt = '0;
    end
    if (s_q.tmo) begin
      s_d.tmo = 1'b0;
      s_d.tcnt = '0;
      if (s_q.arm && !s_q.run) begin
        s_d.addr = ADDR_EMPTY;
        s_d.enter = 1'b0;
        s_d.perr = 1'b0;
      end
    end
    // Registered outputs
    s_d.downshift = s_q.ild || (s_q.bid && i_upper_case);
    s_d.motor = s_q.enter || s_q.ild;
    s_d.unlock = s_q.enter && !s_q.perr && !lock && !s_q.bid;
    s_d.enter_lamp = s_q.enter && !(warn && s_q.blink);
    s_d.status = !s_q.enter;
  end

  // Power-on reset clears all state including arming, and sets status
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s_q <= '0;
      s_q.status <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Bit writes queue here so a slow store back-pressures timing
  bit_fifo #(
    .WIDTH(WR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_in_valid(push),
    .i_in_data(push_data),
    .o_in_ready(fifo_rdy),
    .o_out_valid(o_wr_valid),
    .o_out_data(o_wr_data),
    .i_out_ready(i_wr_ready)
  );

  assign o_downshift = s_q.downshift;
  assign o_motor_on = s_q.motor;
  assign o_kbd_unlock = s_q.unlock;
  assign o_bell = s_q.bell;
  assign o_enter_lamp = s_q.enter_lamp;
  assign o_standby_lamp = s_q.status;
  assign o_status = s_q.status;
  assign o_parity_error = s_q.perr;
  assign o_hold_loaded = s_q.loaded;
  assign o_text_nonselected = s_q.tns;
  assign o_send_request = s_q.send_req;
  assign o_printback_start = s_q.pb_start;

  // Checks beside the logic
  a_entry_gate: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(s_q.enter) |-> $past(!i_upper_case && s_q.addr == ADDR_EMPTY))
    else $error("entry set without lower case and empty address");
  a_addr_advance: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    start && !i_reset_key && !s_q.tmo |=> s_q.addr == $past(s_q.addr) + 1'b1
      && s_q.cnt == BT_FIRST)
    else $error("store start did not advance address");
  a_bit_staging: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_q.run && s_q.ph == PH_STAGE && s_q.cnt != BT_LAST
      |=> s_q.stage == $past(s_q.hold[s_q.cnt]))
    else $error("wrong holding bit staged");
  a_parity_check: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    push && fifo_rdy && s_q.cnt == BT_CBIT && !s_q.par && !i_reset_key
      |=> s_q.perr ##1 !s_q.unlock)
    else $error("parity fault not flagged");
  a_store_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    done |=> !s_q.loaded && s_q.hold == '0 && !s_q.par && !s_q.run)
    else $error("store done did not clear holding");
  a_backspace_step: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_backspace_key && s_q.enter && !s_q.run && !s_q.loaded && !i_enter_key
      && s_q.addr != ADDR_EMPTY && !s_q.rst_pend && !s_q.tmo && !i_printback_done
      |=> s_q.addr == $past(s_q.addr) - 1'b1 && !s_q.run)
    else $error("backspace did not step back");
  a_lock_near_end: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_q.enter && lock |=> !o_kbd_unlock)
    else $error("keyboard open near buffer end");
  a_empty_send: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_send_key && s_q.enter && !s_q.bid && s_q.addr == ADDR_EMPTY && !s_q.loaded
      && !s_q.run && !s_q.entry_req |=> !s_q.enter ##1 !s_q.loaded)
    else $error("empty send did not end entry");
  a_marker_ends: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    done && s_q.stop |=> !s_q.enter ##2 !o_enter_lamp)
    else $error("end marker did not end entry");
  a_idle_restart: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_q.loaded || i_enter_key || i_line_return_key || i_line_type_key |=> s_q.tcnt == '0)
    else $error("idle delay not restarted");
  c_char_store: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    start ##[1:40] done);
  c_end_marker: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    done && s_q.stop);
  c_idle_expiry: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    s_q.tmo && s_q.arm);
endmodule : msg_store_ctrl

/* tb/keyed_printer_model.sv */
// Behavioural keyed printer with transmit, strobe and cycle contacts
module keyed_printer_model
  import msg_store_pkg::*;
(
  input wire logic i_sys_clk,
  // Keystroke request from the bench
  input wire logic i_press,
  input wire logic [CHAR_W-1:0] i_code,
  // Shift mechanism
  input wire logic i_downshift,
  output logic o_upper_case,
  // Transmit and timing contacts
  output logic [CHAR_W-1:0] o_key_bits,
  output logic o_strobe,
  output logic o_io_cycle
);
  timeunit 1ns;
  timeprecision 1ns;
  int phase = 0;
  int shift_cnt = 0;
  logic [CHAR_W-1:0] code_q = '0;
  initial begin
    o_upper_case = 1'b1;
    o_key_bits = 7'h55;
    o_strobe = 1'b0;
    o_io_cycle = 1'b0;
  end
  // Downshift needs a few cycles of travel; contacts span strobe and cycle
  always @(posedge i_sys_clk) begin
    if (i_downshift && o_upper_case) begin
      shift_cnt <= shift_cnt + 1;
    end
    if (shift_cnt == 4) begin
      o_upper_case <= 1'b0;
    end
    if (i_press && phase == 0) begin
      phase <= 1;
      code_q <= i_code;
    end else if (phase != 0) begin
      phase <= (phase == 14) ? 0 : phase + 1;
    end
    // Released lines wander so stale bits cannot pass
    o_key_bits <= (phase >= 1 && phase <= 11) ? code_q : ~o_key_bits;
    o_strobe <= phase >= 2 && phase <= 5;
    o_io_cycle <= phase >= 4 && phase <= 9;
  end
endmodule : keyed_printer_model

/* tb/testbench.sv */
// Self-checking bench for the keyed message store controller
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import msg_store_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic comm = 1'b0;
  logic rec_chk = 1'b0;
  logic wr_rdy = 1'b1;
  logic lr_key = 1'b0, lt_key = 1'b0, halt = 1'b0;
  logic [6:0] keys = '0; // enter, pb_done, bs, reset, send, answerback, press
  logic [CHAR_W-1:0] code = '0;
  logic [CHAR_W-1:0] key_bits;
  logic strobe, io_cyc, upper, dshift, motor, unlock, bell, lamp, standby, status;
  logic perr, hold, tns, send_req, pb_start, wr_v;
  logic [WR_W-1:0] wr_d;
  logic [1:0] obs;
  logic [ADDR_W-1:0] exp_addr = '0;
  logic [WR_W-1:0] wq[$];
  int fails = 0, comparisons = 0, bells = 0, pb_seen = 0, tns_seen = 0;
  int ds_seen = 0, early = 0, b0 = 0;
  assign obs = {lamp, hold};
  always #25 clk = ~clk;
  msg_store_ctrl #(.IDLE_CYCLES(50)) u_dut (.i_sys_clk(clk), .i_reset(rst),
    .i_enter_key(keys[0]), .i_printback_done(keys[1]), .i_backspace_key(keys[2]),
    .i_reset_key(keys[3]), .i_send_key(keys[4]), .i_line_return_key(lr_key),
    .i_line_type_key(lt_key), .i_communicate(comm), .i_record_check(rec_chk),
    .i_answerback_tx(keys[5]), .i_single_cycle_halt(halt), .i_key_bits(key_bits),
    .i_strobe(strobe), .i_io_cycle(io_cyc), .i_upper_case(upper), .o_downshift(dshift),
    .o_motor_on(motor), .o_kbd_unlock(unlock), .o_bell(bell), .o_enter_lamp(lamp),
    .o_standby_lamp(standby), .o_status(status), .o_parity_error(perr),
    .o_hold_loaded(hold), .o_text_nonselected(tns), .o_send_request(send_req),
    .o_printback_start(pb_start), .o_wr_valid(wr_v), .o_wr_data(wr_d),
    .i_wr_ready(wr_rdy));
  keyed_printer_model u_printer (.i_sys_clk(clk), .i_press(keys[6]), .i_code(code),
    .i_downshift(dshift), .o_upper_case(upper), .o_key_bits(key_bits),
    .o_strobe(strobe), .o_io_cycle(io_cyc));
  // Write capture and event counts; the store stalls at random
  always @(posedge clk) begin
    if (wr_v && wr_rdy) begin
      wq.push_back(wr_d);
      early += strobe;
    end
    bells += bell;
    pb_seen += pb_start;
    tns_seen += tns;
    ds_seen += dshift;
    wr_rdy <= ($urandom % 4) != 0;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // Bounded wait on a watched output, then compared
  task automatic wait_lvl(input int k, input logic lvl, input int lim);
    int n;
    n = 0;
    while (obs[k] !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(16'(obs[k]), 16'(lvl));
  endtask : wait_lvl
  task automatic pulse(input int k);
    @(posedge clk);
    keys[k] <= 1'b1;
    @(posedge clk);
    keys[k] <= 1'b0;
  endtask : pulse
  function automatic logic [CHAR_W-1:0] odd_code();
    logic [CHAR_W-1:0] c;
    c = CHAR_W'($urandom);
    if (($countones(c) % 2) == 0) begin
      c[6] = ~c[6];
    end
    return c;
  endfunction : odd_code
  // Seven bit writes at the advanced address, bit time order
  task automatic check_store(input logic [CHAR_W-1:0] c);
    int n;
    n = 0;
    while (wq.size() < 7 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check(16'(wq.size()), 16'h0007);
    for (int b = 0; b < 7 && wq.size() > 0; b++) begin
      check(16'(wq.pop_front()), 16'({exp_addr, 3'(b), c[b]}));
    end
  endtask : check_store
  task automatic type_char(input logic [CHAR_W-1:0] c);
    @(posedge clk);
    code <= c;
    pulse(6);
    wait_lvl(0, 1'b1, 30);
    wait_lvl(0, 1'b0, 200);
    exp_addr++;
    check_store(c);
  endtask : type_char
  // Enter key held until entry is reported
  task automatic start_enter;
    @(posedge clk);
    keys[0] <= 1'b1;
    wait_lvl(1, 1'b1, 100);
    @(posedge clk);
    keys[0] <= 1'b0;
    exp_addr = ADDR_EMPTY;
  endtask : start_enter
  initial begin
    void'($urandom(41));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(16'({status, standby, lamp, motor}), 16'h000C);
    start_enter();
    check(16'({ds_seen > 0, upper}), 16'h0002);
    repeat (2) @(posedge clk);
    check(16'({status, standby, lamp, motor, unlock}), 16'h0007);
    repeat (5) type_char(odd_code());
    pulse(2);
    exp_addr--;
    type_char(odd_code());
    rec_chk <= 1'b1;
    pulse(4);
    wait_lvl(1, 1'b0, 300);
    exp_addr++;
    check_store(MARK_CHECKED);
    check(16'(pb_seen * 2 + send_req), 16'h0002);
    pulse(1);
    wait_lvl(1, 1'b1, 100);
    start_enter();
    pulse(4);
    repeat (4) @(posedge clk);
    check(16'({lamp, wq.size() != 0}), 16'h0000);
    start_enter();
    type_char(odd_code() ^ 7'h01);
    repeat (3) @(posedge clk);
    check(16'({perr, unlock, bells > 0}), 16'h0005);
    pulse(3);
    repeat (3) @(posedge clk);
    check(16'({perr, lamp, tns_seen > 0}), 16'h0000);
    comm <= 1'b1;
    pulse(5);
    start_enter();
    repeat (40) @(posedge clk);
    check(16'(lamp), 16'h0001);
    wait_lvl(1, 1'b0, 20);
    start_enter();
    repeat (30) @(posedge clk);
    type_char(odd_code());
    repeat (35) @(posedge clk);
    check(16'(lamp), 16'h0001);
    // Halt holds off expiry; line keys restart the delay
    halt <= 1'b1;
    repeat (30) @(posedge clk);
    check(16'(lamp), 16'h0001);
    lr_key <= 1'b1;
    halt <= 1'b0;
    @(posedge clk);
    lr_key <= 1'b0;
    repeat (40) @(posedge clk);
    check(16'(lamp), 16'h0001);
    lt_key <= 1'b1;
    @(posedge clk);
    lt_key <= 1'b0;
    repeat (40) @(posedge clk);
    check(16'(lamp), 16'h0001);
    wait_lvl(1, 1'b0, 30);
    pulse(3);
    repeat (3) @(posedge clk);
    check(16'({tns_seen, lamp}), 16'h0002);
    comm <= 1'b0;
    start_enter();
    while (exp_addr < LOCK_FROM) begin
      if (exp_addr == WARN_FROM - 1) begin
        b0 = bells;
      end
      type_char(odd_code());
    end
    repeat (3) @(posedge clk);
    check(16'({bells > b0, unlock}), 16'h0002);
    // Communicate send with the plain marker
    comm <= 1'b1;
    rec_chk <= 1'b0;
    pulse(4);
    wait_lvl(1, 1'b0, 300);
    exp_addr++;
    check_store(MARK_PLAIN);
    check(16'(pb_seen * 2 + send_req), 16'h0003);
    check(16'(early), 16'h0000);
    results();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    results();
  end
endmodule : testbench
